/* File: hdl/ccs_top.sv */
// cpu clock source select: apb registers, oscillator control, cpu clock
//
// How it works
// RL1: divider codes 0-4 give /1../16
// RL2: select bit picks subclock or main clock
// RL3: divider ignored while on subclock
// RL4: cpu source status follows real switch
// RL5: main status shows internal or external
// RL6: main stop bit gates external source
// RL7: internal osc stop bit, stable flag
// RL8: low-speed stop bit stops that oscillator
// RL9: both bits make x2 driven input
// RL10: software sets range above 10 MHz
// RL11: both mode bits select external main
// RL12: software restarts internal osc before leaving sub
// RL13: driven input needs no settle wait
// RL14: software stops main only after switch
// RL15: software makes x2 an input first
// RL16: software checks pin toggles before use
// RL17: subclock cpu, two periods per instruction
// RL18: software stops internal osc after switch
// RL19: no truncated cpu clock pulses
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module ccs_top
  import ccs_pkg::*;
#(
  parameter int unsigned OST_TICKS = OST_TICKS_DEF // crystal settle edges
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ccs_ticks_t ticks,
  output logic cpu_clk,
  output logic cpu_rise,
  output logic instr_slot,
  output logic hs_osc_en,
  output logic ls_osc_en,
  output logic ext_osc_en,
  output ccs_x2_mode_t x2_mode,
  output logic amp_high,
  output logic periph_ext_sel
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0] div; // divider code
    logic src_sel; // cpu_source_select
    logic hs_stop; // internal_hs_osc_stop
    logic ls_stop; // internal_ls_osc_stop
    logic [7:0] hs_cnt; // internal osc settle count
    logic hs_stable; // internal_hs_osc_stable
    logic main_stop; // main_osc_stop
    logic ext_sel; // external_source_select, set once
    logic mode_sel; // main_clock_mode_sel
    logic hf_range; // high_freq_range
    logic pinsel; // oscillator_pin_select
    logic drv; // driven_clock_input
    logic [4:0] ost; // settle stages
    logic [16:0] ost_cnt; // crystal edge count
    logic [31:0] rdata; // read data
    logic slot; // second rise of an instruction
    logic slot_p; // instruction slot pulse
  } ccs_top_st_t;

  ccs_top_st_t s_q; // registered state
  ccs_top_st_t s_d; // next state
  ccs_gen_req_t req; // clock request
  ccs_gen_st_t gen; // generator status
  ccs_ticks_t live; // gated oscillator edges
  logic wr; // write takes effect
  logic rd_setup; // read data captured
  logic hit; // mapped address
  logic driven; // x2 driven clock mode
  logic ext_ready; // external source usable
  logic [7:0] a; // low address bits

  // stage threshold for settle bit n (bit 0 last)
  function automatic logic [16:0] ost_lim(input int n);
    logic [31:0] t;
    t = 32'(OST_TICKS) >> n;
    return t[16:0];
  endfunction : ost_lim

  // ****************************************
  // bus decode
  // ****************************************
  assign a = paddr[7:0];
  assign hit = (paddr[31:8] == 24'h000000) && (a[1:0] == 2'b00) && (a <= ADR_OST);
  assign wr = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ****************************************
  // oscillator gating and clock request
  // ****************************************
  always_comb
  begin
    // RL9 both bits give driven input
    driven = s_q.pinsel && s_q.drv;
    if (driven)
    begin
      x2_mode = X2_DRIVEN;
    end
    else if (s_q.pinsel)
    begin
      x2_mode = X2_XTAL;
    end
    else
    begin
      x2_mode = X2_PORT;
    end
    // RL13 driven input skips settle wait
    ext_ready = !s_q.main_stop && s_q.pinsel && (driven || s_q.ost[0]);
    // RL7 stopped internal osc gives no edges
    live.hs = ticks.hs && !s_q.hs_stop;
    // RL6 external edges only when enabled
    live.ext = ticks.ext && !s_q.main_stop && s_q.pinsel;
    live.sub = ticks.sub;
    // RL11 both mode bits select external
    req.ext = s_q.ext_sel && s_q.mode_sel && ext_ready;
    req.sub = s_q.src_sel;
    req.div = s_q.div;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.slot_p = 1'b0;
    // RL7 settle count after start
    if (s_q.hs_stop)
    begin
      s_d.hs_cnt = 8'h00;
      s_d.hs_stable = 1'b0;
    end
    else if (live.hs && !s_q.hs_stable)
    begin
      s_d.hs_cnt = s_q.hs_cnt + 8'h01;
      s_d.hs_stable = (s_q.hs_cnt == HS_STAB_TICKS - 8'h01);
    end
    // crystal settle stages, cleared while stopped
    if (s_q.main_stop || !s_q.pinsel || driven)
    begin
      s_d.ost_cnt = 17'h00000;
      s_d.ost = 5'h00;
    end
    else if (live.ext && !s_q.ost[0])
    begin
      s_d.ost_cnt = s_q.ost_cnt + 17'h00001;
      for (int n = 0; n < 5; n++)
      begin
        if (s_d.ost_cnt == ost_lim(n))
        begin
          s_d.ost[n] = 1'b1;
        end
      end
    end
    // RL17 instruction every two cpu periods
    if (gen.rise)
    begin
      s_d.slot = ~s_q.slot;
      s_d.slot_p = s_q.slot;
    end
    // register writes
    if (wr)
    begin
      case (a)
        ADR_PROC_CLK:
        begin
          // RL1 store divider code
          s_d.div = pwdata[PROC_DIV_LSB +: 3];
          // RL2 cpu source select
          s_d.src_sel = pwdata[PROC_SEL_BIT];
        end
        ADR_IOM:
        begin
          s_d.hs_stop = pwdata[IOM_HS_STOP_BIT];
          // RL8 low-speed osc stop
          s_d.ls_stop = pwdata[IOM_LS_STOP_BIT];
        end
        ADR_MAIN_OSC:
        begin
          // RL6 main osc stop bit
          s_d.main_stop = pwdata[MAIN_OSC_STOP_BIT];
        end
        ADR_MAIN_MODE:
        begin
          s_d.mode_sel = pwdata[MODE_SEL_BIT];
          // external select sticks until reset
          s_d.ext_sel = s_q.ext_sel | pwdata[MODE_EXT_BIT];
        end
        ADR_OSC:
        begin
          s_d.hf_range = pwdata[OSC_AMP_BIT];
          s_d.pinsel = pwdata[OSC_PINSEL_BIT];
          s_d.drv = pwdata[OSC_DRIVEN_BIT];
        end
        default:
        begin
          s_d.rdata = s_q.rdata;
        end
      endcase
    end
    // read data captured in setup phase
    if (rd_setup)
    begin
      s_d.rdata = RD_ZERO;
      // unmapped addresses fall to the zero branch
      case (hit ? a : 8'hff)
        ADR_PROC_CLK:
        begin
          s_d.rdata[PROC_DIV_LSB +: 3] = s_q.div;
          s_d.rdata[PROC_SEL_BIT] = s_q.src_sel;
          // RL4 actual cpu source
          s_d.rdata[PROC_STAT_BIT] = gen.on_sub;
        end
        ADR_IOM:
        begin
          s_d.rdata[IOM_HS_STOP_BIT] = s_q.hs_stop;
          s_d.rdata[IOM_LS_STOP_BIT] = s_q.ls_stop;
          s_d.rdata[IOM_HS_STABLE_BIT] = s_q.hs_stable;
        end
        ADR_MAIN_OSC:
        begin
          s_d.rdata[MAIN_OSC_STOP_BIT] = s_q.main_stop;
        end
        ADR_MAIN_MODE:
        begin
          s_d.rdata[MODE_SEL_BIT] = s_q.mode_sel;
          // RL5 actual main source
          s_d.rdata[MODE_STAT_BIT] = gen.main_ext;
          s_d.rdata[MODE_EXT_BIT] = s_q.ext_sel;
        end
        ADR_OSC:
        begin
          s_d.rdata[OSC_AMP_BIT] = s_q.hf_range;
          s_d.rdata[OSC_PINSEL_BIT] = s_q.pinsel;
          s_d.rdata[OSC_DRIVEN_BIT] = s_q.drv;
        end
        ADR_OST:
        begin
          s_d.rdata[4:0] = s_q.ost;
        end
        default:
        begin
          s_d.rdata = RD_ZERO;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q <= '{div: DIV_RST, src_sel: 1'b0, hs_stop: 1'b0, ls_stop: 1'b0,
               hs_cnt: 8'h00, hs_stable: 1'b0, main_stop: MAIN_STOP_RST, ext_sel: 1'b0,
               mode_sel: 1'b0, hf_range: 1'b0, pinsel: 1'b0, drv: 1'b0, ost: 5'h00,
               ost_cnt: 17'h00000, rdata: RD_ZERO, slot: 1'b0, slot_p: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // cpu clock generator
  // ****************************************
  // RL19 switching done glitch-free inside
  ccs_clk_gen ccs_clk_gen_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .ticks(live),
    .req(req),
    .st(gen)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = s_q.rdata;
  assign cpu_clk = gen.clk;
  assign cpu_rise = gen.rise;
  assign instr_slot = s_q.slot_p;
  assign hs_osc_en = !s_q.hs_stop;
  assign ls_osc_en = !s_q.ls_stop;
  assign ext_osc_en = !s_q.main_stop && s_q.pinsel;
  assign amp_high = s_q.hf_range;
  assign periph_ext_sel = gen.main_ext;

endmodule : ccs_top

`default_nettype wire

/* File: hdl/ccs_pkg.sv */
// package: constants and types of the cpu clock source select block
package ccs_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] ADR_PROC_CLK = 8'h00; // processor_clock_control
  localparam logic [7:0] ADR_IOM = 8'h04; // internal_osc_mode
  localparam logic [7:0] ADR_MAIN_OSC = 8'h08; // main_osc_control
  localparam logic [7:0] ADR_MAIN_MODE = 8'h0c; // main_clock_mode
  localparam logic [7:0] ADR_OSC = 8'h10; // oscillator_control
  localparam logic [7:0] ADR_OST = 8'h14; // osc_stabilize_status

  // ****************************************
  // field positions
  // ****************************************
  localparam int PROC_DIV_LSB = 0; // divider code, 3 bits
  localparam int PROC_SEL_BIT = 4; // cpu_source_select
  localparam int PROC_STAT_BIT = 5; // cpu_source_status, read only
  localparam int IOM_HS_STOP_BIT = 0; // internal_hs_osc_stop
  localparam int IOM_LS_STOP_BIT = 1; // internal_ls_osc_stop
  localparam int IOM_HS_STABLE_BIT = 7; // internal_hs_osc_stable, read only
  localparam int MAIN_OSC_STOP_BIT = 7; // main_osc_stop
  localparam int MODE_SEL_BIT = 0; // main_clock_mode_sel
  localparam int MODE_STAT_BIT = 1; // main_clock_status, read only
  localparam int MODE_EXT_BIT = 2; // external_source_select
  localparam int OSC_AMP_BIT = 0; // high_freq_range
  localparam int OSC_PINSEL_BIT = 6; // oscillator_pin_select
  localparam int OSC_DRIVEN_BIT = 7; // driven_clock_input

  // ****************************************
  // reset values and limits
  // ****************************************
  localparam logic [2:0] DIV_RST = 3'h1; // main clock / 2
  localparam logic [2:0] DIV_MAX = 3'h4; // main clock / 16
  localparam logic MAIN_STOP_RST = 1'h1; // external source stopped
  localparam logic [31:0] RD_ZERO = 32'h00000000;

  // ****************************************
  // timing counts, in oscillator edges
  // ****************************************
  localparam logic [7:0] HS_STAB_TICKS = 8'h40; // internal osc settle
  localparam int OST_TICKS_DEF = 65536; // crystal settle, last stage

  // ****************************************
  // types
  // ****************************************
  // oscillator edge pulses, one per half period
  typedef struct packed {
    logic hs;
    logic ext;
    logic sub;
  } ccs_ticks_t;

  // function of the x2 pin
  typedef enum logic [1:0] {
    X2_PORT = 2'b00,
    X2_XTAL = 2'b01,
    X2_DRIVEN = 2'b10
  } ccs_x2_mode_t;

  // requested cpu clock setup
  typedef struct packed {
    logic sub;
    logic ext;
    logic [2:0] div;
  } ccs_gen_req_t;

  // clock generator state
  typedef struct packed {
    logic clk;
    logic on_sub;
    logic main_ext;
    logic rise;
    logic [2:0] div;
    logic [3:0] cnt;
  } ccs_gen_st_t;

endpackage : ccs_pkg

/* File: hdl/ccs_clk_gen.sv */
// glitch-free cpu clock generator from oscillator edge pulses
`timescale 1ns/1ps
`default_nettype none

module ccs_clk_gen
  import ccs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire ccs_ticks_t ticks,
  input wire ccs_gen_req_t req,
  output ccs_gen_st_t st
);

  // ****************************************
  // state
  // ****************************************
  ccs_gen_st_t s_q; // registered state
  ccs_gen_st_t s_d; // next state
  logic src_tick; // edge of the live source
  logic [3:0] lim; // last count of a half period

  // half period length minus one for a divider code
  function automatic logic [3:0] half_lim(input logic [2:0] code);
    logic [3:0] r;
    r = 4'h0;
    case (code)
      3'h0: r = 4'h0;
      3'h1: r = 4'h1;
      3'h2: r = 4'h3;
      3'h3: r = 4'h7;
      default: r = 4'hf;
    endcase
    return r;
  endfunction : half_lim

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    s_d = s_q;
    s_d.rise = 1'b0;
    // RL3 sub ignores divider
    lim = s_q.on_sub ? 4'h0 : half_lim(s_q.div);
    src_tick = s_q.on_sub ? ticks.sub : (s_q.main_ext ? ticks.ext : ticks.hs);
    // main source free to move while cpu is on sub
    if (s_q.on_sub)
    begin
      s_d.main_ext = req.ext;
    end
    if (src_tick)
    begin
      if (s_q.cnt == lim)
      begin
        s_d.cnt = 4'h0;
        s_d.clk = ~s_q.clk;
        // RL19 change only after a full low phase
        if (!s_q.clk)
        begin
          s_d.rise = 1'b1;
          // RL2 source select taken here
          s_d.on_sub = req.sub;
          s_d.main_ext = req.ext;
          // RL1 legal codes only
          if (req.div <= DIV_MAX)
          begin
            s_d.div = req.div;
          end
        end
      end
      else
      begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s_q <= '{clk: 1'b0, on_sub: 1'b0, main_ext: 1'b0, rise: 1'b0,
               div: DIV_RST, cnt: 4'h0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign st = s_q;

endmodule : ccs_clk_gen

`default_nettype wire

/* File: tb/ccs_osc_model.sv */
// oscillator model: edge pulses of the hs, external and sub sources
`timescale 1ns/1ps
`default_nettype none

module ccs_osc_model
  import ccs_pkg::*;
(
  input wire logic clk,
  input wire logic hs_en,
  input wire logic ext_en,
  output ccs_ticks_t ticks
);
  logic [2:0] ph_q = 3'h0; // free running phase of the sources

  // ****
  // source phase
  // ****
  // phase counter, runs regardless of reset
  always_ff @(posedge clk)
  begin
    ph_q <= ph_q + 3'h1;
  end

  // ****
  // edge pulses
  // ****
  // hs edges only while enabled
  assign ticks.hs = hs_en;
  // external edges only while enabled, every second cycle
  assign ticks.ext = ext_en & ph_q[0];
  // subclock never stops, one edge per eight cycles
  assign ticks.sub = (ph_q == 3'h7);
endmodule : ccs_osc_model

`default_nettype wire

/* File: tb/ccs_top_asserts.sv */
// checker: port-level assertions of the cpu clock source select block
`timescale 1ns/1ps
`default_nettype none

module ccs_top_chk
  import ccs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire ccs_ticks_t ticks,
  input wire logic cpu_clk,
  input wire logic cpu_rise,
  input wire logic instr_slot,
  input wire logic hs_osc_en,
  input wire logic ls_osc_en,
  input wire logic ext_osc_en,
  input wire ccs_x2_mode_t x2_mode,
  input wire logic periph_ext_sel
);
  // ****
  // clocking and helpers
  // ****
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic wr; // completed apb write
  assign wr = psel & penable & pwrite;

  // ****
  // properties
  // ****
  // rise pulse exact
  property p_rise;
    cpu_rise == $rose(cpu_clk);
  endproperty
  a_rise: assert property (p_rise) else $error("cpu_rise off its edge");
  property p_tick;
    $changed(cpu_clk) |-> $past(ticks) != 3'h0;
  endproperty
  a_tick: assert property (p_tick) else $error("cpu clock moved without tick");
  property p_hs;
    wr && paddr == {24'h0, ADR_IOM} |=> hs_osc_en == !$past(pwdata[IOM_HS_STOP_BIT]);
  endproperty
  a_hs: assert property (p_hs) else $error("hs enable wrong");
  property p_ls;
    wr && paddr == {24'h0, ADR_IOM} |=> ls_osc_en == !$past(pwdata[IOM_LS_STOP_BIT]);
  endproperty
  a_ls: assert property (p_ls) else $error("ls enable wrong");
  property p_ext;
    ext_osc_en |-> x2_mode != X2_PORT;
  endproperty
  a_ext: assert property (p_ext) else $error("external enabled on port pin");
  property p_x2;
    wr && paddr == {24'h0, ADR_OSC} && pwdata[7:6] == 2'h3 |=> x2_mode == X2_DRIVEN;
  endproperty
  a_x2: assert property (p_x2) else $error("x2 not driven input");
  property p_per;
    $changed(periph_ext_sel) |-> cpu_clk || $past(cpu_clk);
  endproperty
  a_per: assert property (p_per) else $error("main status moved mid phase");
  property p_sel;
    $rose(periph_ext_sel) |-> ext_osc_en;
  endproperty
  a_sel: assert property (p_sel) else $error("external selected while off");
  // slot pulse only after a rise
  property p_slot;
    instr_slot |-> $past(cpu_rise);
  endproperty
  a_slot: assert property (p_slot) else $error("instruction slot off a rise");
endmodule : ccs_top_chk

bind ccs_top ccs_top_chk ccs_top_chk_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ticks(ticks),
  .cpu_clk(cpu_clk), .cpu_rise(cpu_rise), .instr_slot(instr_slot),
  .hs_osc_en(hs_osc_en), .ls_osc_en(ls_osc_en),
  .ext_osc_en(ext_osc_en), .x2_mode(x2_mode), .periph_ext_sel(periph_ext_sel));

`default_nettype wire

/* File: tb/ccs_top_tb_top.sv */
// testbench: apb driven scenarios for the cpu clock source select block
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); \
    end \
  end

module ccs_top_tb_top
  import ccs_pkg::*;
;
  logic clk = 1'b0; // 40 MHz
  logic sys_rst = 1'b1; // held two cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_clk, cpu_rise, instr_slot;
  logic hs_osc_en, ls_osc_en, ext_osc_en, amp_high, periph_ext_sel;
  ccs_x2_mode_t x2_mode; // pin function
  ccs_ticks_t ticks; // source edges
  int mismatches = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;

  ccs_top #(.OST_TICKS(64)) ccs_top_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ticks(ticks), .cpu_clk(cpu_clk),
    .cpu_rise(cpu_rise), .instr_slot(instr_slot), .hs_osc_en(hs_osc_en),
    .ls_osc_en(ls_osc_en), .ext_osc_en(ext_osc_en), .x2_mode(x2_mode),
    .amp_high(amp_high), .periph_ext_sel(periph_ext_sel));
  ccs_osc_model ccs_osc_model_inst (.clk(clk), .hs_en(hs_osc_en), .ext_en(ext_osc_en),
    .ticks(ticks));

  // ****
  // bus and measuring tasks
  // ****
  // one apb transfer, then one idle edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {24'h0, a}, {24'h0, d}, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, {24'h0, a}, 32'h0, r, e);
  endtask : rd
  // reads until a bit shows the wanted level
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    logic [31:0] r;
    do rd(a, r); while (r[b] !== v);
  endtask : poll
  // cycles between two cpu rising edges, second interval
  task automatic per(output logic [7:0] n);
    repeat (2)
    begin
      n = 8'h0;
      do @(negedge clk); while (cpu_rise !== 1'b1);
      do
      begin
        @(negedge clk);
        n++;
      end
      while (cpu_rise !== 1'b1);
    end
  endtask : per
  // cycles between two instruction slot pulses
  task automatic slot_gap(output logic [7:0] n);
    n = 8'h0;
    do @(negedge clk); while (instr_slot !== 1'b1);
    do
    begin
      @(negedge clk);
      n++;
    end
    while (instr_slot !== 1'b1);
    @(posedge clk);
  endtask : slot_gap

  // ****
  // scenarios
  // ****
  task automatic t_reset;
    logic [31:0] v;
    rd(ADR_PROC_CLK, v);
    `CHK(v, 32'h01)
    rd(ADR_MAIN_OSC, v);
    `CHK(v, 32'h80)
    `CHK({hs_osc_en, ext_osc_en}, 2'h2)
    `CHK(x2_mode, X2_PORT)
  endtask : t_reset
  task automatic t_div;
    logic [31:0] v;
    logic [7:0] n;
    for (int d = 0; d < 5; d++)
    begin
      wr(ADR_PROC_CLK, 8'(d));
      per(n);
      `CHK(n, 8'h2 << d)
    end
    wr(ADR_PROC_CLK, 8'h05);
    rd(ADR_PROC_CLK, v);
    `CHK(v, 32'h05)
    per(n);
    `CHK(n, 8'h20)
    wr(ADR_PROC_CLK, 8'h01);
    rd(ADR_IOM, v);
    `CHK(v, 32'h80)
  endtask : t_div
  task automatic t_sub;
    logic [31:0] v;
    logic [7:0] n;
    wr(ADR_PROC_CLK, 8'h14);
    poll(ADR_PROC_CLK, PROC_STAT_BIT, 1'b1);
    per(n);
    `CHK(n, 8'h10)
    wr(ADR_IOM, 8'h03);
    `CHK({hs_osc_en, ls_osc_en}, 2'h0)
    rd(ADR_IOM, v);
    `CHK(v, 32'h03)
    per(n);
    `CHK(n, 8'h10)
    slot_gap(n);
    `CHK(n, 8'h20)
    wr(ADR_IOM, 8'h00);
    poll(ADR_IOM, IOM_HS_STABLE_BIT, 1'b1);
    wr(ADR_PROC_CLK, 8'h01);
    poll(ADR_PROC_CLK, PROC_STAT_BIT, 1'b0);
    per(n);
    `CHK(n, 8'h04)
  endtask : t_sub
  task automatic t_ext;
    logic [31:0] v;
    logic [7:0] n;
    // crystal mode first, settle stages must run
    wr(ADR_OSC, 8'h40);
    `CHK(x2_mode, X2_XTAL)
    wr(ADR_MAIN_OSC, 8'h00);
    `CHK(ext_osc_en, 1'b1)
    n = 8'h00;
    repeat (8)
    begin
      @(negedge clk);
      n = n + 8'(ticks.ext);
    end
    @(posedge clk);
    `CHK(n, 8'h04)
    poll(ADR_OST, 0, 1'b1);
    rd(ADR_OST, v);
    `CHK(v, 32'h1f)
    // slow driven input, pin set up
    wr(ADR_OSC, 8'hc0);
    `CHK(x2_mode, X2_DRIVEN)
    rd(ADR_OST, v);
    `CHK(v, 32'h00)
    wr(ADR_MAIN_MODE, 8'h05);
    poll(ADR_MAIN_MODE, MODE_STAT_BIT, 1'b1);
    `CHK(periph_ext_sel, 1'b1)
    rd(ADR_MAIN_MODE, v);
    `CHK(v, 32'h07)
    wr(ADR_IOM, 8'h01);
    per(n);
    `CHK(n, 8'h08)
  endtask : t_ext
  task automatic t_bad;
    logic [31:0] v;
    logic e;
    apb(1'b1, 32'h1, 32'h10, v, e);
    `CHK(e, 1'b1)
    rd(ADR_PROC_CLK, v);
    `CHK(v, 32'h01)
    // fast input range bit, set by software
    wr(ADR_OSC, 8'hc1);
    `CHK(amp_high, 1'b1)
    rd(ADR_OSC, v);
    `CHK(v, 32'hc1)
  endtask : t_bad

  // ****
  // verdict
  // ****
  task automatic complete_run;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_div();
    t_sub();
    t_ext();
    t_bad();
    complete_run();
  end
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule : ccs_top_tb_top

`default_nettype wire
